// ---- pkg/lou_regs.svh ----
// Constants of the logic and compare unit: widths, bit positions and reset values.
`ifndef LOU_REGS_SVH
`define LOU_REGS_SVH

`define LOU_DATA_W     8
`define LOU_SIGN_BIT   7
`define LOU_HALF_W     4
`define LOU_WORK_RST   8'h00
`define LOU_FLAGS_RST  4'h0
`define LOU_ZERO_BYTE  8'h00
`define LOU_ONES_BYTE  8'hFF

`endif

// ---- pkg/lou_pkg.sv ----
// Types and a shared helper of the logic and compare unit.
`include "lou_regs.svh"

package lou_pkg;

    typedef enum logic [3:0] {
        LOU_NOP,
        LOU_LOAD_W,
        LOU_AND_W,
        LOU_AND_M,
        LOU_OR_W,
        LOU_OR_M,
        LOU_XOR_W,
        LOU_XOR_M,
        LOU_XOR_IO,
        LOU_NOT_W,
        LOU_NOT_M,
        LOU_NEG_W,
        LOU_NEG_M,
        LOU_CMP_WM,
        LOU_CMP_MW
    } lou_op_t;

    typedef struct packed {
        logic null_flag;
        logic borrow_flag;
        logic half_borrow_flag;
        logic signed_range_flag;
    } lou_flags_t;

    typedef struct packed {
        lou_op_t                 op;
        logic [`LOU_DATA_W-1:0]  operand;
    } lou_req_t;

    function automatic logic lou_is_zero(input logic [`LOU_DATA_W-1:0] v);
        return v == `LOU_ZERO_BYTE;
    endfunction : lou_is_zero

endpackage : lou_pkg

// ---- hw/lou_sub.sv ----
// Eight-bit subtractor that yields the difference and all four flags.
`timescale 1ns/100ps
`include "lou_regs.svh"

module lou_sub (
    // Operands
    input  wire logic [`LOU_DATA_W-1:0] minuend,
    input  wire logic [`LOU_DATA_W-1:0] subtrahend,
    // Result
    output logic [`LOU_DATA_W-1:0]      diff,
    output lou_pkg::lou_flags_t         flags
);
    import lou_pkg::*;

    logic [`LOU_DATA_W:0] wide;
    logic [`LOU_HALF_W:0] low;

    assign wide = {1'b0, minuend} - {1'b0, subtrahend};
    assign low  = {1'b0, minuend[`LOU_HALF_W-1:0]} - {1'b0, subtrahend[`LOU_HALF_W-1:0]};
    assign diff = wide[`LOU_DATA_W-1:0];

    // The ninth bit of the widened difference is the unsigned borrow.
    assign flags.null_flag         = lou_is_zero(wide[`LOU_DATA_W-1:0]); // RULE14
    assign flags.borrow_flag       = wide[`LOU_DATA_W]; // RULE15
    assign flags.half_borrow_flag  = low[`LOU_HALF_W];
    // Signed overflow: operands differ in sign and the result sign follows the subtrahend.
    assign flags.signed_range_flag = (minuend[`LOU_SIGN_BIT] ^ subtrahend[`LOU_SIGN_BIT])
                                   & (minuend[`LOU_SIGN_BIT] ^ wide[`LOU_SIGN_BIT]);

endmodule : lou_sub

// ---- hw/lou_top.sv ----
// Logic, complement and compare datapath around the work register and four flags.
//
// Summary of operation
// RULE1: AND into work register, null flag only.
// RULE2: AND into memory byte, null flag only.
// RULE3: OR into work register, null flag only.
// RULE4: OR into memory byte, null flag only.
// RULE5: XOR into work register, null flag only.
// RULE6: XOR into memory byte, null flag only.
// RULE7: XOR into I/O register, no flags change.
// RULE8: Invert work register, null flag from result.
// RULE9: Invert memory byte, null flag only.
// RULE10: Negate work register, null flag only.
// RULE11: Negate memory byte, null flag only.
// RULE12: Compare work minus memory, all flags, no writes.
// RULE13: Compare memory minus work, all flags, no writes.
// RULE14: Equal compare operands set null flag.
// RULE15: Smaller unsigned minuend sets borrow flag.
// RULE16: Eight-bit data; null flag means zero result.
`timescale 1ns/100ps
`include "lou_regs.svh"

module lou_top (
    // Clock, reset and clock enable
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   CE,
    // Operation request
    input  wire logic                   REQ_VALID,
    input  wire lou_pkg::lou_req_t      REQ,
    // Work register and flags
    output logic [`LOU_DATA_W-1:0]      WORK_REG,
    output lou_pkg::lou_flags_t         FLAGS,
    // Memory write-back
    output logic                        MEM_WE,
    output logic [`LOU_DATA_W-1:0]      MEM_WDATA,
    // I/O register write-back
    output logic                        IO_WE,
    output logic [`LOU_DATA_W-1:0]      IO_WDATA,
    // Completion
    output logic                        DONE
);
    import lou_pkg::*;

    logic [`LOU_DATA_W-1:0] work_register;
    logic [`LOU_DATA_W-1:0] next_work_register;
    lou_flags_t             flags;
    lou_flags_t             next_flags;
    logic                   mem_we;
    logic                   next_mem_we;
    logic [`LOU_DATA_W-1:0] mem_wdata;
    logic [`LOU_DATA_W-1:0] next_mem_wdata;
    logic                   io_we;
    logic                   next_io_we;
    logic [`LOU_DATA_W-1:0] io_wdata;
    logic [`LOU_DATA_W-1:0] next_io_wdata;
    logic                   done;
    logic                   next_done;

    logic                   take;
    logic [`LOU_DATA_W-1:0] opnd;
    logic [`LOU_DATA_W-1:0] sub_a;
    logic [`LOU_DATA_W-1:0] sub_b;
    logic [`LOU_DATA_W-1:0] sub_diff;
    lou_flags_t             sub_flags;

    assign take = CE & REQ_VALID;
    assign opnd = REQ.operand;

    // One subtractor serves both compares and both negations (zero minus operand).
    always_comb begin
        sub_a = work_register;
        sub_b = opnd;
        case (REQ.op)
            LOU_CMP_MW: begin
                sub_a = opnd; // RULE13
                sub_b = work_register;
            end
            LOU_NEG_W: begin
                sub_a = `LOU_ZERO_BYTE; // RULE10
                sub_b = work_register;
            end
            LOU_NEG_M: begin
                sub_a = `LOU_ZERO_BYTE; // RULE11
                sub_b = opnd;
            end
            default: begin
                sub_a = work_register; // RULE12
                sub_b = opnd;
            end
        endcase
    end

    lou_sub u_sub (
        .minuend    (sub_a),
        .subtrahend (sub_b),
        .diff       (sub_diff),
        .flags      (sub_flags)
    );

    // Logic ops touch only the null flag; the other three keep their values.
    always_comb begin
        next_work_register = work_register;
        next_flags         = flags;
        next_mem_we        = 1'b0;
        next_mem_wdata     = mem_wdata;
        next_io_we         = 1'b0;
        next_io_wdata      = io_wdata;
        next_done          = take;
        if (take) begin
            case (REQ.op)
                LOU_LOAD_W: begin
                    next_work_register = opnd;
                end
                LOU_AND_W: begin
                    next_work_register   = work_register & opnd; // RULE1
                    next_flags.null_flag = lou_is_zero(work_register & opnd); // RULE16
                end
                LOU_AND_M: begin
                    next_mem_we          = 1'b1;
                    next_mem_wdata       = work_register & opnd; // RULE2
                    next_flags.null_flag = lou_is_zero(work_register & opnd);
                end
                LOU_OR_W: begin
                    next_work_register   = work_register | opnd; // RULE3
                    next_flags.null_flag = lou_is_zero(work_register | opnd);
                end
                LOU_OR_M: begin
                    next_mem_we          = 1'b1;
                    next_mem_wdata       = work_register | opnd; // RULE4
                    next_flags.null_flag = lou_is_zero(work_register | opnd);
                end
                LOU_XOR_W: begin
                    next_work_register   = work_register ^ opnd; // RULE5
                    next_flags.null_flag = lou_is_zero(work_register ^ opnd);
                end
                LOU_XOR_M: begin
                    next_mem_we          = 1'b1;
                    next_mem_wdata       = work_register ^ opnd; // RULE6
                    next_flags.null_flag = lou_is_zero(work_register ^ opnd);
                end
                LOU_XOR_IO: begin
                    next_io_we    = 1'b1;
                    next_io_wdata = work_register ^ opnd; // RULE7
                end
                LOU_NOT_W: begin
                    next_work_register   = ~work_register; // RULE8
                    next_flags.null_flag = lou_is_zero(~work_register);
                end
                LOU_NOT_M: begin
                    next_mem_we          = 1'b1;
                    next_mem_wdata       = ~opnd; // RULE9
                    next_flags.null_flag = lou_is_zero(~opnd);
                end
                LOU_NEG_W: begin
                    next_work_register   = sub_diff; // RULE10
                    next_flags.null_flag = sub_flags.null_flag;
                end
                LOU_NEG_M: begin
                    next_mem_we          = 1'b1;
                    next_mem_wdata       = sub_diff; // RULE11
                    next_flags.null_flag = sub_flags.null_flag;
                end
                LOU_CMP_WM, LOU_CMP_MW: begin
                    next_flags = sub_flags; // RULE12 RULE13
                end
                default: begin
                    next_flags = flags;
                end
            endcase
        end
    end

    // CE low holds every register, including the one-cycle strobes.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            work_register <= `LOU_WORK_RST;
            flags         <= `LOU_FLAGS_RST;
            mem_we        <= 1'b0;
            mem_wdata     <= `LOU_ZERO_BYTE;
            io_we         <= 1'b0;
            io_wdata      <= `LOU_ZERO_BYTE;
            done          <= 1'b0;
        end else if (CE) begin
            work_register <= next_work_register;
            flags         <= next_flags;
            mem_we        <= next_mem_we;
            mem_wdata     <= next_mem_wdata;
            io_we         <= next_io_we;
            io_wdata      <= next_io_wdata;
            done          <= next_done;
        end
    end

    assign WORK_REG  = work_register;
    assign FLAGS     = flags;
    assign MEM_WE    = mem_we;
    assign MEM_WDATA = mem_wdata;
    assign IO_WE     = io_we;
    assign IO_WDATA  = io_wdata;
    assign DONE      = done;

    and_work_a: assert property ( // RULE1
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_AND_W |=>
            WORK_REG == ($past(WORK_REG) & $past(opnd)) && !MEM_WE
            && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("AND into work register wrong");

    and_mem_a: assert property ( // RULE2
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_AND_M |=>
            MEM_WE && MEM_WDATA == ($past(WORK_REG) & $past(opnd))
            && WORK_REG == $past(WORK_REG) && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("AND into memory wrong");

    or_work_a: assert property ( // RULE3
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_OR_W |=>
            WORK_REG == ($past(WORK_REG) | $past(opnd))
            && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("OR into work register wrong");

    or_mem_a: assert property ( // RULE4
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_OR_M |=>
            MEM_WE && MEM_WDATA == ($past(WORK_REG) | $past(opnd))
            && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("OR into memory wrong");

    xor_work_a: assert property ( // RULE5
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_XOR_W |=>
            WORK_REG == ($past(WORK_REG) ^ $past(opnd))
            && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("XOR into work register wrong");

    xor_mem_a: assert property ( // RULE6
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_XOR_M |=>
            MEM_WE && MEM_WDATA == ($past(WORK_REG) ^ $past(opnd)) && !IO_WE)
        else $error("XOR into memory wrong");

    xor_io_a: assert property ( // RULE7
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_XOR_IO |=>
            IO_WE && !MEM_WE && IO_WDATA == ($past(WORK_REG) ^ $past(opnd))
            && FLAGS == $past(FLAGS))
        else $error("XOR into I/O register wrong");

    not_work_a: assert property ( // RULE8
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_NOT_W |=>
            WORK_REG == ~$past(WORK_REG) && FLAGS.null_flag == ($past(WORK_REG) == 8'hFF))
        else $error("Inversion of work register wrong");

    not_mem_a: assert property ( // RULE9
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_NOT_M |=>
            MEM_WE && MEM_WDATA == ~$past(opnd) && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("Inversion of memory wrong");

    neg_work_a: assert property ( // RULE10
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_NEG_W |=>
            WORK_REG + $past(WORK_REG) == 8'h00 && FLAGS[2:0] == $past(FLAGS[2:0]))
        else $error("Negation of work register wrong");

    neg_mem_a: assert property ( // RULE11
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_NEG_M |=>
            MEM_WE && MEM_WDATA + $past(opnd) == 8'h00 && WORK_REG == $past(WORK_REG))
        else $error("Negation of memory wrong");

    cmp_keep_a: assert property ( // RULE12
        @(posedge CLK) disable iff (!RESET_N)
        take && (REQ.op == LOU_CMP_WM || REQ.op == LOU_CMP_MW) |=>
            !MEM_WE && !IO_WE && WORK_REG == $past(WORK_REG) && DONE)
        else $error("Compare wrote an operand");

    cmp_reverse_a: assert property ( // RULE13
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_CMP_MW |=>
            FLAGS.borrow_flag == ($past(opnd) < $past(WORK_REG)))
        else $error("Reversed compare borrow wrong");

    cmp_equal_a: assert property ( // RULE14
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_CMP_WM && opnd == WORK_REG |=>
            FLAGS.null_flag && !FLAGS.borrow_flag && !FLAGS.signed_range_flag)
        else $error("Equal compare did not set null flag");

    cmp_borrow_a: assert property ( // RULE15
        @(posedge CLK) disable iff (!RESET_N)
        take && REQ.op == LOU_CMP_WM |=>
            FLAGS.borrow_flag == ($past(WORK_REG) < $past(opnd)) && !FLAGS.null_flag
            == ($past(WORK_REG) != $past(opnd)))
        else $error("Compare borrow flag wrong");

    null_zero_a: assert property ( // RULE16
        @(posedge CLK) disable iff (!RESET_N)
        take && (REQ.op == LOU_AND_M || REQ.op == LOU_XOR_M) |=>
            FLAGS.null_flag == (MEM_WDATA == 8'h00))
        else $error("Null flag disagrees with result");

    idle_hold_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !take |=> !DONE && !MEM_WE && !IO_WE || !$past(CE))
        else $error("Strobe without request");

endmodule : lou_top

// ---- verif/lou_top_test.sv ----
// Self-checking testbench of the logic and compare unit with a queued reference model.
`timescale 1ns/100ps
`include "lou_regs.svh"

`define LOU_CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[ERR] %0t mismatch got %h want %h", $time, got, exp); \
    end \
end

module lou_top_test;
    import lou_pkg::*;

    typedef struct packed {
        logic [`LOU_DATA_W-1:0] work;
        lou_flags_t             flags;
        logic                   mem_we;
        logic [`LOU_DATA_W-1:0] mem_wdata;
        logic                   io_we;
        logic [`LOU_DATA_W-1:0] io_wdata;
    } lou_note_t;

    localparam int      N_DIR = 22;
    localparam lou_op_t D_OP [0:N_DIR-1] = '{
        LOU_LOAD_W, LOU_CMP_WM, LOU_CMP_WM, LOU_AND_W, LOU_NOT_W, LOU_LOAD_W,
        LOU_NOT_W, LOU_LOAD_W, LOU_NEG_W, LOU_CMP_MW, LOU_AND_M, LOU_OR_M,
        LOU_XOR_M, LOU_XOR_IO, LOU_NOT_M, LOU_NEG_M, LOU_NEG_M, LOU_LOAD_W,
        LOU_CMP_WM, LOU_NOP, LOU_XOR_W, LOU_OR_W};
    localparam logic [7:0] D_OPND [0:N_DIR-1] = '{
        8'h38, 8'h38, 8'h42, 8'h0F, 8'h00, 8'h38, 8'h00, 8'h38, 8'h00, 8'h80, 8'h37,
        8'h00, 8'hC8, 8'h55, 8'hFF, 8'h00, 8'h38, 8'h38, 8'h80, 8'h00, 8'h38, 8'h00};

    logic                   CLK;
    logic                   RESET_N;
    logic                   CE;
    logic                   REQ_VALID;
    lou_req_t               REQ;
    logic [`LOU_DATA_W-1:0] WORK_REG;
    lou_flags_t             FLAGS;
    logic                   MEM_WE;
    logic [`LOU_DATA_W-1:0] MEM_WDATA;
    logic                   IO_WE;
    logic [`LOU_DATA_W-1:0] IO_WDATA;
    logic                   DONE;

    int          fails = 0;
    int          check_count = 0;
    lou_note_t   note_q [$];
    lou_note_t   m;
    lou_note_t   mon_e;
    logic [31:0] seed = 32'h052A;

    lou_top i_dut (
        .CLK       (CLK),
        .RESET_N   (RESET_N),
        .CE        (CE),
        .REQ_VALID (REQ_VALID),
        .REQ       (REQ),
        .WORK_REG  (WORK_REG),
        .FLAGS     (FLAGS),
        .MEM_WE    (MEM_WE),
        .MEM_WDATA (MEM_WDATA),
        .IO_WE     (IO_WE),
        .IO_WDATA  (IO_WDATA),
        .DONE      (DONE)
    );

    initial begin
        CLK = 1'b0;
        RESET_N = 1'b0;
        CE = 1'b0;
        REQ_VALID = 1'b0;
        REQ = '0;
        m = '0;
    end

    always #12.5 CLK = ~CLK;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr

    function automatic lou_flags_t sub_flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return '{null_flag: (d == 8'h00), borrow_flag: (a < b),
                 half_borrow_flag: (a[3:0] < b[3:0]),
                 signed_range_flag: (a[7] != b[7]) && (d[7] != a[7])};
    endfunction : sub_flags

    task automatic give_verdict;
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Drives one cycle and, when the request will be taken, notes the expected outcome.
    task automatic issue(input lou_op_t op, input logic [7:0] o, input logic ce, input logic v);
        lou_note_t  e;
        logic [7:0] r;
        @(posedge CLK);
        CE <= ce;
        REQ_VALID <= v;
        REQ <= '{op: op, operand: o};
        if (ce && v) begin
            e = m;
            e.mem_we = 1'b0;
            e.io_we = 1'b0;
            case (op)
                LOU_AND_W, LOU_AND_M:             r = m.work & o;
                LOU_OR_W, LOU_OR_M:               r = m.work | o;
                LOU_XOR_W, LOU_XOR_M, LOU_XOR_IO: r = m.work ^ o;
                LOU_NOT_W:                        r = ~m.work;
                LOU_NOT_M:                        r = ~o;
                LOU_NEG_W:                        r = 8'h00 - m.work;
                LOU_NEG_M:                        r = 8'h00 - o;
                default:                          r = o;
            endcase
            case (op)
                LOU_LOAD_W: e.work = r;
                LOU_AND_W, LOU_OR_W, LOU_XOR_W, LOU_NOT_W, LOU_NEG_W: begin
                    e.work = r;
                    e.flags.null_flag = (r == 8'h00);
                end
                LOU_AND_M, LOU_OR_M, LOU_XOR_M, LOU_NOT_M, LOU_NEG_M: begin
                    e.mem_we = 1'b1;
                    e.mem_wdata = r;
                    e.flags.null_flag = (r == 8'h00);
                end
                LOU_XOR_IO: begin
                    e.io_we = 1'b1;
                    e.io_wdata = r;
                end
                LOU_CMP_WM: e.flags = sub_flags(m.work, o);
                LOU_CMP_MW: e.flags = sub_flags(o, m.work);
                default: ;
            endcase
            m = e;
            note_q.push_back(e);
        end
    endtask : issue

    task automatic drain;
        int n;
        for (n = 0; n < 20 && note_q.size() > 0; n++)
            issue(LOU_NOP, 8'h00, 1'b1, 1'b0);
        if (note_q.size() > 0) begin
            fails++;
            $display("[ERR] %0t results still missing after drain", $time);
            give_verdict;
        end
    endtask : drain

    task automatic do_reset;
        @(posedge CLK);
        RESET_N <= 1'b0;
        CE <= 1'b1;
        REQ_VALID <= 1'b0;
        repeat (16) @(posedge CLK);
        `LOU_CHK(WORK_REG, `LOU_WORK_RST)
        `LOU_CHK(FLAGS, `LOU_FLAGS_RST)
        RESET_N <= 1'b1;
        m = '0;
    endtask : do_reset

    // Each result shows for one enabled edge after its request; compare it with the oldest note.
    always @(posedge CLK) begin
        if (RESET_N === 1'b1 && CE === 1'b1 && DONE === 1'b1) begin
            if (note_q.size() == 0) begin
                fails++;
                $display("[ERR] %0t result without request", $time);
            end else begin
                mon_e = note_q.pop_front();
                `LOU_CHK(WORK_REG, mon_e.work)
                `LOU_CHK(FLAGS, mon_e.flags)
                `LOU_CHK(MEM_WE, mon_e.mem_we)
                `LOU_CHK(MEM_WDATA, mon_e.mem_wdata)
                `LOU_CHK(IO_WE, mon_e.io_we)
                `LOU_CHK(IO_WDATA, mon_e.io_wdata)
            end
        end
    end

    initial begin
        repeat (60000) @(posedge CLK);
        fails++;
        $display("[ERR] %0t run did not finish in time", $time);
        give_verdict;
    end

    initial begin
        do_reset();
        for (int i = 0; i < N_DIR; i++)
            issue(D_OP[i], D_OPND[i], 1'b1, 1'b1);
        for (int i = 0; i < 4000; i++) begin
            seed = lfsr(seed);
            issue(lou_op_t'(seed[3:0] % 4'hF), (seed[13:12] == 2'h0) ? m.work : seed[23:16],
                  seed[8] | seed[9], seed[10] | seed[11]);
        end
        drain();
        do_reset();
        for (int i = 0; i < N_DIR; i++)
            issue(D_OP[N_DIR-1-i], D_OPND[i], 1'b1, 1'b1);
        drain();
        give_verdict();
    end

endmodule : lou_top_test
